// ### src/adcp_pkg.sv
package adcp_pkg;

    // Channel count and data width; the width covers the widest signed range the block meets.
    localparam int NUM_CH = 4;
    localparam int DW = 18;

    // Signed channel value.
    typedef logic signed [DW-1:0] adcp_data_t;

    // Input range codes, one per documented input signal scope.
    localparam logic [2:0] RANGE_0_10V = 3'h0;
    localparam logic [2:0] RANGE_PM10V = 3'h1;
    localparam logic [2:0] RANGE_0_5V = 3'h2;
    localparam logic [2:0] RANGE_PM5V = 3'h3;
    localparam logic [2:0] RANGE_1_5V = 3'h4;
    localparam logic [2:0] RANGE_0_20MA = 3'h5;
    localparam logic [2:0] RANGE_PM20MA = 3'h6;
    localparam logic [2:0] RANGE_4_20MA = 3'h7;

    // Digital output scope of the standard variant.
    localparam adcp_data_t STD_UNI_LO = 18'sh00000;
    localparam adcp_data_t STD_UNI_HI = 18'sh03FFF;
    localparam adcp_data_t STD_BIP_LO = -18'sh02000;
    localparam adcp_data_t STD_BIP_HI = 18'sh01FFF;
    // Digital output scope of the high-resolution variant (0..80000, -80000..80000).
    localparam adcp_data_t HR_UNI_LO = 18'sh00000;
    localparam adcp_data_t HR_BIP_LO = -18'sh13880;
    localparam adcp_data_t HR_HI = 18'sh13880;
    // Alert limit bounds of the high-resolution variant (-82000..82000).
    localparam adcp_data_t HR_LIM_LO = -18'sh14050;
    localparam adcp_data_t HR_LIM_HI = 18'sh14050;

    // Span divisors of the scaling map, sized for the product they divide.
    localparam logic signed [39:0] SPAN_STD = 40'sh00_0000_3FFF;
    localparam logic signed [39:0] SPAN_HR_UNI = 40'sh00_0001_3880;
    localparam logic signed [39:0] SPAN_HR_BIP = 40'sh00_0002_7100;

    // Open-wire thresholds (-32767 and -16000) and substitute levels.
    localparam adcp_data_t BURN_THR_STD = -18'sh07FFF;
    localparam adcp_data_t BURN_THR_HR = -18'sh03E80;
    localparam adcp_data_t BURN_LOW = 18'sh00000;
    localparam adcp_data_t BURN_HIGH_STD = 18'sh07FFF;
    localparam adcp_data_t BURN_HIGH_HR = 18'sh1FFFF;

    // Alert limit reset values (5000 and 0).
    localparam adcp_data_t ALERT_UPPER_RST = 18'sh01388;
    localparam adcp_data_t ALERT_LOWER_RST = 18'sh00000;

    // Per-channel configuration written by the controller.
    typedef struct packed {
        logic alert_en;
        logic scale_en;
        logic rec_en;
        logic burn_en;
        logic burn_high;
        logic [2:0] in_range;
        adcp_data_t alert_uu;
        adcp_data_t alert_lu;
        adcp_data_t alert_ul;
        adcp_data_t alert_ll;
        adcp_data_t scale_hi;
        adcp_data_t scale_lo;
    } adcp_chan_cfg_t;

    // Per-channel results seen by the controller.
    typedef struct packed {
        adcp_data_t value;
        logic alert;
        logic burnout;
        adcp_data_t max;
        adcp_data_t min;
        logic max_valid;
        logic min_valid;
    } adcp_chan_out_t;

    // Per-channel state.
    typedef struct packed {
        adcp_chan_cfg_t cfg;
        adcp_data_t value;
        logic alert_hi;
        logic alert_lo;
        logic burnout;
        adcp_data_t max;
        adcp_data_t min;
        logic max_valid;
        logic min_valid;
        logic max_req_prev;
        logic min_req_prev;
    } adcp_chan_state_t;

    // Whole block state.
    typedef struct packed {
        adcp_chan_state_t [NUM_CH-1:0] ch;
        logic result_valid;
        logic [1:0] result_chan;
    } adcp_state_t;

    // Reset configuration: every function closed, range 0-10 V, limits at their presets.
    localparam adcp_chan_cfg_t CFG_RESET = '{
        alert_uu: ALERT_UPPER_RST, alert_lu: ALERT_UPPER_RST,
        alert_ul: ALERT_LOWER_RST, alert_ll: ALERT_LOWER_RST,
        in_range: RANGE_0_10V, default: '0};
    localparam adcp_chan_state_t CH_RESET = '{cfg: CFG_RESET, default: '0};

endpackage

// ### src/adcp_postprocess.sv
`timescale 1ns/1ps
`default_nettype none

module adcp_postprocess (
    input wire logic clock,
    input wire logic reset,
    input wire logic high_resolution_input_variant,
    input wire logic sample_valid,
    input wire logic [1:0] sample_chan,
    input wire adcp_pkg::adcp_data_t sample_value,
    input wire logic cfg_write,
    input wire logic [1:0] cfg_chan,
    input wire adcp_pkg::adcp_chan_cfg_t cfg_data,
    input wire logic [adcp_pkg::NUM_CH-1:0] max_clear_req,
    input wire logic [adcp_pkg::NUM_CH-1:0] min_clear_req,
    output logic result_valid,
    output logic [1:0] result_chan,
    output var adcp_pkg::adcp_chan_out_t [adcp_pkg::NUM_CH-1:0] chan_out
);

    // Registered state and its next value.
    adcp_pkg::adcp_state_t st;
    adcp_pkg::adcp_state_t next_st;

    // Datapath signals for the channel named by the incoming sample.
    adcp_pkg::adcp_chan_cfg_t cur_cfg;
    adcp_pkg::adcp_data_t cur_lo;
    adcp_pkg::adcp_data_t cur_hi;
    adcp_pkg::adcp_data_t lim_lo;
    adcp_pkg::adcp_data_t lim_hi;
    adcp_pkg::adcp_data_t eff_uu;
    adcp_pkg::adcp_data_t eff_lu;
    adcp_pkg::adcp_data_t eff_ul;
    adcp_pkg::adcp_data_t eff_ll;
    adcp_pkg::adcp_data_t cur_sub;
    adcp_pkg::adcp_data_t cur_dig;
    adcp_pkg::adcp_data_t cur_scaled;
    adcp_pkg::adcp_data_t cur_val;
    adcp_pkg::adcp_data_t cur_shi;
    adcp_pkg::adcp_data_t cur_slo;
    logic cur_bip;
    logic cur_burn_range;
    logic cur_burn;
    logic cur_above_uu;
    logic cur_below_lu;
    logic cur_below_ll;
    logic cur_above_ul;
    // Wide intermediates of the scaling map; the product needs far more than 18 bits.
    logic signed [39:0] diff;
    logic signed [39:0] prod;
    logic signed [39:0] quot;

    // Limits outside the variant's allowed span are pulled back in rather than refused.
    function automatic adcp_pkg::adcp_data_t clamp(
        input adcp_pkg::adcp_data_t v,
        input adcp_pkg::adcp_data_t lo,
        input adcp_pkg::adcp_data_t hi
    );
        if (v < lo) begin
            return lo;
        end
        if (v > hi) begin
            return hi;
        end
        return v;
    endfunction

    // Datapath for the sampled channel: bounds, open-wire check, scaling and alert compares.
    always_comb begin
        cur_cfg = st.ch[sample_chan].cfg;
        cur_shi = cur_cfg.scale_hi;
        cur_slo = cur_cfg.scale_lo;
        cur_bip = (cur_cfg.in_range == adcp_pkg::RANGE_PM10V) || (cur_cfg.in_range == adcp_pkg::RANGE_PM5V)
            || (cur_cfg.in_range == adcp_pkg::RANGE_PM20MA);
        // Digital output scope of the channel, by variant and range.
        if (high_resolution_input_variant) begin
            cur_lo = cur_bip ? adcp_pkg::HR_BIP_LO : adcp_pkg::HR_UNI_LO;
            cur_hi = adcp_pkg::HR_HI;
            lim_lo = adcp_pkg::HR_LIM_LO;
            lim_hi = adcp_pkg::HR_LIM_HI;
        end else begin
            cur_lo = cur_bip ? adcp_pkg::STD_BIP_LO : adcp_pkg::STD_UNI_LO;
            cur_hi = cur_bip ? adcp_pkg::STD_BIP_HI : adcp_pkg::STD_UNI_HI;
            lim_lo = cur_lo;
            lim_hi = cur_hi;
        end
        // Open wire is only meaningful on live-zero ranges.
        cur_burn_range = (cur_cfg.in_range == adcp_pkg::RANGE_1_5V)
            || (cur_cfg.in_range == adcp_pkg::RANGE_4_20MA);
        if (high_resolution_input_variant) begin
            cur_burn = cur_cfg.burn_en && cur_burn_range && (sample_value < adcp_pkg::BURN_THR_HR);
            cur_sub = cur_cfg.burn_high ? adcp_pkg::BURN_HIGH_HR : adcp_pkg::BURN_LOW;
        end else begin
            cur_burn = cur_cfg.burn_en && cur_burn_range && (sample_value < adcp_pkg::BURN_THR_STD);
            cur_sub = cur_cfg.burn_high ? adcp_pkg::BURN_HIGH_STD : adcp_pkg::BURN_LOW;
        end
        // During open wire the substitute stands in for the conversion result.
        cur_dig = cur_burn ? cur_sub : sample_value;
        // Linear map; the controller keeps upper above lower, so the slope is never zero or negative.
        diff = 40'(sample_value) - 40'(cur_lo);
        prod = diff * (40'(cur_shi) - 40'(cur_slo));
        if (!high_resolution_input_variant) begin
            quot = prod / adcp_pkg::SPAN_STD;
        end else if (cur_bip) begin
            quot = prod / adcp_pkg::SPAN_HR_BIP;
        end else begin
            quot = prod / adcp_pkg::SPAN_HR_UNI;
        end
        cur_scaled = 18'(40'(cur_slo) + quot);
        // Scaling is bypassed when closed and when a substitute is being sent.
        cur_val = (cur_cfg.scale_en && !cur_burn) ? cur_scaled : cur_dig;
        // The alert window is judged on the digital output value, before scaling.
        eff_uu = clamp(cur_cfg.alert_uu, lim_lo, lim_hi);
        eff_lu = clamp(cur_cfg.alert_lu, lim_lo, lim_hi);
        eff_ul = clamp(cur_cfg.alert_ul, lim_lo, lim_hi);
        eff_ll = clamp(cur_cfg.alert_ll, lim_lo, lim_hi);
        // The gap between each pair of limits gives hysteresis; the ordering is the controller's duty.
        cur_above_uu = cur_dig > eff_uu;
        cur_below_lu = cur_dig < eff_lu;
        cur_below_ll = cur_dig < eff_ll;
        cur_above_ul = cur_dig > eff_ul;
    end

    // Next-state logic for every channel; each channel's settings are independent.
    always_comb begin
        next_st = st;
        next_st.result_valid = sample_valid;
        next_st.result_chan = sample_valid ? sample_chan : st.result_chan;
        for (int i = 0; i < adcp_pkg::NUM_CH; i++) begin
            // Clear requests act on their rising edge only; holding the request does nothing more.
            next_st.ch[i].max_req_prev = max_clear_req[i];
            next_st.ch[i].min_req_prev = min_clear_req[i];
            if (max_clear_req[i] && !st.ch[i].max_req_prev) begin
                next_st.ch[i].max_valid = 1'b0;
            end
            if (min_clear_req[i] && !st.ch[i].min_req_prev) begin
                next_st.ch[i].min_valid = 1'b0;
            end
            // A configuration write takes effect from the next sample of that channel.
            if (cfg_write && (cfg_chan == 2'(i))) begin
                next_st.ch[i].cfg = cfg_data;
            end
            // A new result for this channel is evaluated against its own settings.
            if (sample_valid && (sample_chan == 2'(i))) begin
                next_st.ch[i].value = cur_val;
                next_st.ch[i].burnout = cur_burn;
                if (cur_above_uu) begin
                    next_st.ch[i].alert_hi = 1'b1;
                end else if (cur_below_lu) begin
                    next_st.ch[i].alert_hi = 1'b0;
                end
                if (cur_below_ll) begin
                    next_st.ch[i].alert_lo = 1'b1;
                end else if (cur_above_ul) begin
                    next_st.ch[i].alert_lo = 1'b0;
                end
                // A clear in this same cycle empties the record first, so this sample seeds it.
                if (cur_cfg.rec_en) begin
                    if (!next_st.ch[i].max_valid || (cur_val > st.ch[i].max)) begin
                        next_st.ch[i].max = cur_val;
                    end
                    if (!next_st.ch[i].min_valid || (cur_val < st.ch[i].min)) begin
                        next_st.ch[i].min = cur_val;
                    end
                    next_st.ch[i].max_valid = 1'b1;
                    next_st.ch[i].min_valid = 1'b1;
                end
            end
            // Closed alerting and open-wire checks show no flag, whatever they showed before closing.
            if (!next_st.ch[i].cfg.alert_en) begin
                next_st.ch[i].alert_hi = 1'b0;
                next_st.ch[i].alert_lo = 1'b0;
            end
            if (!next_st.ch[i].cfg.burn_en) begin
                next_st.ch[i].burnout = 1'b0;
            end
        end
    end

    // State register; reset restores every channel to its closed preset.
    always_ff @(posedge clock) begin
        if (reset) begin
            st <= '{ch: '{default: adcp_pkg::CH_RESET}, default: '0};
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state register.
    always_comb begin
        result_valid = st.result_valid;
        result_chan = st.result_chan;
        for (int i = 0; i < adcp_pkg::NUM_CH; i++) begin
            chan_out[i].value = st.ch[i].value;
            chan_out[i].alert = st.ch[i].alert_hi || st.ch[i].alert_lo;
            chan_out[i].burnout = st.ch[i].burnout;
            chan_out[i].max = st.ch[i].max;
            chan_out[i].min = st.ch[i].min;
            chan_out[i].max_valid = st.ch[i].max_valid;
            chan_out[i].min_valid = st.ch[i].min_valid;
        end
    end

    // All checks run on the one clock and are off while reset is high.
    default clocking adcp_cb @(posedge clock);
    endclocking
    default disable iff (reset);

    // The max-clear request of channel 0 rising with no channel-0 sample in the way.
    sequence s_max_clear;
        $rose(max_clear_req[0]) && !(sample_valid && (sample_chan == 2'h0));
    endsequence

    // The same for the min-clear request.
    sequence s_min_clear;
        $rose(min_clear_req[0]) && !(sample_valid && (sample_chan == 2'h0));
    endsequence

    // A channel-0 sample that finds recording closed.
    sequence s_rec_closed;
        sample_valid && (sample_chan == 2'h0) && !cur_cfg.rec_en && !max_clear_req[0] && !min_clear_req[0];
    endsequence

    property p_alert_set;
        sample_valid && cur_cfg.alert_en && (cur_above_uu || cur_below_ll) && !(cfg_write && (cfg_chan == sample_chan))
            |=> chan_out[$past(sample_chan)].alert;
    endproperty
    a_alert_set: assert property (p_alert_set) else $error("Alert flag missed an out-of-window value.");

    property p_alert_off;
        sample_valid && !cur_cfg.alert_en && !(cfg_write && (cfg_chan == sample_chan))
            |=> !chan_out[$past(sample_chan)].alert;
    endproperty
    a_alert_off: assert property (p_alert_off) else $error("Alert flag set while alerting closed.");

    property p_scale_bottom;
        sample_valid && cur_cfg.scale_en && !cur_burn && (sample_value == cur_lo)
            |=> chan_out[$past(sample_chan)].value == $past(cur_slo);
    endproperty
    a_scale_bottom: assert property (p_scale_bottom) else $error("Scaled bottom differs from lower limit.");

    property p_scale_top;
        sample_valid && cur_cfg.scale_en && !cur_burn && (sample_value == cur_hi)
            |=> chan_out[$past(sample_chan)].value == $past(cur_shi);
    endproperty
    a_scale_top: assert property (p_scale_top) else $error("Scaled top differs from upper limit.");

    property p_scale_bypass;
        sample_valid && !cur_cfg.scale_en && !cur_burn
            |=> chan_out[$past(sample_chan)].value == $past(sample_value);
    endproperty
    a_scale_bypass: assert property (p_scale_bypass) else $error("Value altered with scaling closed.");

    property p_record_bounds;
        sample_valid && cur_cfg.rec_en
            |=> (chan_out[$past(sample_chan)].max >= chan_out[$past(sample_chan)].value)
                && (chan_out[$past(sample_chan)].min <= chan_out[$past(sample_chan)].value);
    endproperty
    a_record_bounds: assert property (p_record_bounds) else $error("Held max or min does not bound the value.");

    property p_record_hold;
        s_rec_closed |=> $stable(chan_out[0].max) && $stable(chan_out[0].min);
    endproperty
    a_record_hold: assert property (p_record_hold) else $error("Record moved while recording closed.");

    property p_max_clear;
        s_max_clear |=> !chan_out[0].max_valid;
    endproperty
    a_max_clear: assert property (p_max_clear) else $error("Max-clear request did not empty the max.");

    property p_min_clear;
        s_min_clear |=> !chan_out[0].min_valid;
    endproperty
    a_min_clear: assert property (p_min_clear) else $error("Min-clear request did not empty the min.");

    property p_burn_range;
        sample_valid && !cur_burn_range |=> !chan_out[$past(sample_chan)].burnout;
    endproperty
    a_burn_range: assert property (p_burn_range) else $error("Burn-out flagged on an unsupported range.");

    property p_burn_std;
        sample_valid && !high_resolution_input_variant && cur_cfg.burn_en && cur_burn_range
            && (sample_value < adcp_pkg::BURN_THR_STD) && !(cfg_write && (cfg_chan == sample_chan))
            |=> chan_out[$past(sample_chan)].burnout;
    endproperty
    a_burn_std: assert property (p_burn_std) else $error("Standard open wire not flagged.");

    property p_burn_hr;
        sample_valid && high_resolution_input_variant && cur_cfg.burn_en && cur_burn_range
            && (sample_value < adcp_pkg::BURN_THR_HR) && !(cfg_write && (cfg_chan == sample_chan))
            |=> chan_out[$past(sample_chan)].burnout;
    endproperty
    a_burn_hr: assert property (p_burn_hr) else $error("High-resolution open wire not flagged.");

    property p_sub_std;
        sample_valid && !high_resolution_input_variant && cur_burn
            |=> chan_out[$past(sample_chan)].value == ($past(cur_cfg.burn_high) ? 18'sh07FFF : 18'sh00000);
    endproperty
    a_sub_std: assert property (p_sub_std) else $error("Wrong standard substitute value.");

    property p_sub_hr;
        sample_valid && high_resolution_input_variant && cur_burn
            |=> chan_out[$past(sample_chan)].value == ($past(cur_cfg.burn_high) ? 18'sh1FFFF : 18'sh00000);
    endproperty
    a_sub_hr: assert property (p_sub_hr) else $error("Wrong high-resolution substitute value.");

endmodule // adcp_postprocess

`default_nettype wire

// ### test/adcp_front_end.sv
`timescale 1ns/1ps
`default_nettype none

// Converter front end and controller model: it sends raw results and raises the clear flags.
module adcp_front_end (
    input wire logic clock,
    output logic sample_valid,
    output logic [1:0] sample_chan,
    output adcp_pkg::adcp_data_t sample_value,
    output logic [adcp_pkg::NUM_CH-1:0] max_clear_req,
    output logic [adcp_pkg::NUM_CH-1:0] min_clear_req
);
    // Everything starts idle with all flags off.
    initial begin
        sample_valid = 1'b0;
        sample_chan = 2'h0;
        sample_value = 18'sh00000;
        max_clear_req = 4'h0;
        min_clear_req = 4'h0;
    end

    // One result per call; afterwards the bus shows the inverse so a stale value is never read as fresh.
    task automatic send(input logic [1:0] ch, input adcp_pkg::adcp_data_t v);
        @(negedge clock);
        sample_valid = 1'b1;
        sample_chan = ch;
        sample_value = v;
        @(negedge clock);
        sample_valid = 1'b0;
        sample_value = ~v;
    endtask

    // The flag goes on for one edge and is returned to off once the clear has been taken.
    task automatic clear(input logic [1:0] ch, input logic is_max);
        @(negedge clock);
        if (is_max) begin
            max_clear_req[ch] = 1'b1;
        end else begin
            min_clear_req[ch] = 1'b1;
        end
        @(negedge clock);
        max_clear_req = 4'h0;
        min_clear_req = 4'h0;
    endtask
endmodule // adcp_front_end

`default_nettype wire

// ### test/adcp_postprocess_bench.sv
`timescale 1ns/1ps
`default_nettype none

// Self-checking bench; every scenario drives the block and judges its outputs itself.
module adcp_postprocess_bench;
    logic clock = 1'b0; // 50 MHz clock.
    logic reset = 1'b1; // Synchronous, active high.
    logic hr = 1'b0; // Resolution variant select.
    logic cfg_write = 1'b0;
    logic [1:0] cfg_chan = 2'h0;
    adcp_pkg::adcp_chan_cfg_t cfg_data = adcp_pkg::CFG_RESET;
    logic sample_valid;
    logic [1:0] sample_chan;
    adcp_pkg::adcp_data_t sample_value;
    logic [3:0] max_clear_req;
    logic [3:0] min_clear_req;
    logic result_valid;
    logic [1:0] result_chan;
    adcp_pkg::adcp_chan_out_t [3:0] chan_out;
    int error_cnt = 0;
    int comparisons = 0;
    int cycles = 0;

    // The clock toggles every half period.
    always #10 clock = ~clock;

    adcp_front_end adcp_front_end_i (.clock(clock), .sample_valid(sample_valid), .sample_chan(sample_chan),
        .sample_value(sample_value), .max_clear_req(max_clear_req), .min_clear_req(min_clear_req));

    adcp_postprocess adcp_postprocess_i (.clock(clock), .reset(reset), .high_resolution_input_variant(hr),
        .sample_valid(sample_valid), .sample_chan(sample_chan), .sample_value(sample_value),
        .cfg_write(cfg_write), .cfg_chan(cfg_chan), .cfg_data(cfg_data), .max_clear_req(max_clear_req),
        .min_clear_req(min_clear_req), .result_valid(result_valid), .result_chan(result_chan),
        .chan_out(chan_out));

    // The run takes well under a thousand cycles, so this ceiling only trips on a hang.
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            error_cnt = error_cnt + 1;
            summarize();
        end
    end

    // Case equality so an unknown output never passes.
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // A configuration write is a one-cycle pulse given at the falling edge.
    task automatic cfg(input logic [1:0] ch, input adcp_pkg::adcp_chan_cfg_t c);
        @(negedge clock);
        cfg_write = 1'b1;
        cfg_chan = ch;
        cfg_data = c;
        @(negedge clock);
        cfg_write = 1'b0;
    endtask

    // After reset every function is closed and a sample passes through raw.
    task automatic t_reset;
        chk(chan_out[0].value, 18'h00000);
        adcp_front_end_i.send(2'h0, 18'sh01B58);
        chk({17'h00000, result_valid}, 18'h00001);
        chk(chan_out[0].value, 18'h01B58);
        chk({17'h00000, chan_out[0].alert}, 18'h00000);
        chk({17'h00000, chan_out[0].max_valid}, 18'h00000);
    endtask

    // Alert window with preset limits, and its isolation from another channel.
    task automatic t_alert;
        adcp_pkg::adcp_chan_cfg_t c;
        c = adcp_pkg::CFG_RESET;
        c.alert_en = 1'b1;
        cfg(2'h1, c);
        adcp_front_end_i.send(2'h1, 18'sh01770);
        chk({17'h00000, chan_out[1].alert}, 18'h00001);
        adcp_front_end_i.send(2'h2, 18'sh01770);
        chk({17'h00000, chan_out[2].alert}, 18'h00000);
        chk({15'h0000, result_valid, result_chan}, 18'h00006);
        adcp_front_end_i.send(2'h1, 18'sh01387);
        chk({17'h00000, chan_out[1].alert}, 18'h00000);
        adcp_front_end_i.send(2'h1, -18'sh00001);
        chk({17'h00000, chan_out[1].alert}, 18'h00001);
    endtask

    // Scaling of the 1-5 V range onto 1000..5000 along the documented table.
    task automatic t_scale;
        adcp_pkg::adcp_chan_cfg_t c;
        logic [17:0] raw [5] = '{18'h00000, 18'h01000, 18'h02000, 18'h03000, 18'h03FFF};
        logic [17:0] exp [5] = '{18'h003E8, 18'h007D0, 18'h00BB8, 18'h00FA0, 18'h01388};
        c = adcp_pkg::CFG_RESET;
        c.in_range = adcp_pkg::RANGE_1_5V;
        c.scale_en = 1'b1;
        c.scale_hi = 18'sh01388;
        c.scale_lo = 18'sh003E8;
        cfg(2'h0, c);
        for (int i = 0; i < 5; i++) begin
            adcp_front_end_i.send(2'h0, raw[i]);
            chk(chan_out[0].value, exp[i]);
        end
    endtask

    // Recording of maximum and minimum, then each clear on its own.
    task automatic t_rec;
        adcp_pkg::adcp_chan_cfg_t c;
        c = adcp_pkg::CFG_RESET;
        c.rec_en = 1'b1;
        cfg(2'h0, c);
        adcp_front_end_i.send(2'h0, 18'sh00064);
        adcp_front_end_i.send(2'h0, 18'sh001F4);
        adcp_front_end_i.send(2'h0, 18'sh00032);
        chk(chan_out[0].max, 18'h001F4);
        chk(chan_out[0].min, 18'h00032);
        adcp_front_end_i.clear(2'h0, 1'b1);
        chk({16'h0000, chan_out[0].max_valid, chan_out[0].min_valid}, 18'h00001);
        adcp_front_end_i.clear(2'h0, 1'b0);
        chk({16'h0000, chan_out[0].max_valid, chan_out[0].min_valid}, 18'h00000);
        adcp_front_end_i.send(2'h0, 18'sh00007);
        chk(chan_out[0].max, 18'h00007);
        chk(chan_out[0].min, 18'h00007);
    endtask

    // Open-wire thresholds and substitutes of both variants, and a range where it stays off.
    task automatic t_burn;
        adcp_pkg::adcp_chan_cfg_t c;
        c = adcp_pkg::CFG_RESET;
        c.in_range = adcp_pkg::RANGE_4_20MA;
        c.burn_en = 1'b1;
        cfg(2'h2, c);
        adcp_front_end_i.send(2'h2, -18'sh08000);
        chk({chan_out[2].burnout, chan_out[2].value[16:0]}, 18'h20000);
        adcp_front_end_i.send(2'h2, -18'sh07FFF);
        chk({17'h00000, chan_out[2].burnout}, 18'h00000);
        c.burn_high = 1'b1;
        cfg(2'h2, c);
        adcp_front_end_i.send(2'h2, -18'sh08000);
        chk(chan_out[2].value, 18'h07FFF);
        c.in_range = adcp_pkg::RANGE_0_20MA;
        cfg(2'h2, c);
        adcp_front_end_i.send(2'h2, -18'sh08000);
        chk({17'h00000, chan_out[2].burnout}, 18'h00000);
        hr = 1'b1;
        c.in_range = adcp_pkg::RANGE_1_5V;
        cfg(2'h2, c);
        adcp_front_end_i.send(2'h2, -18'sh03E81);
        chk(chan_out[2].value, 18'h1FFFF);
        adcp_front_end_i.send(2'h2, -18'sh03E80);
        chk({17'h00000, chan_out[2].burnout}, 18'h00000);
        // A bipolar high-resolution range maps -80000..80000 onto -1000..1000.
        c.in_range = adcp_pkg::RANGE_PM10V;
        c.scale_en = 1'b1;
        c.scale_hi = 18'sh003E8;
        c.scale_lo = -18'sh003E8;
        cfg(2'h2, c);
        adcp_front_end_i.send(2'h2, 18'sh00000);
        chk(chan_out[2].value, 18'h00000);
        adcp_front_end_i.send(2'h2, -18'sh13880);
        chk(chan_out[2].value, 18'h3FC18);
    endtask

    // Counts, verdict and end of the run.
    task automatic summarize;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Reset for three cycles, then each scenario in turn.
    initial begin
        repeat (3) @(negedge clock);
        reset = 1'b0;
        t_reset();
        t_alert();
        t_scale();
        t_rec();
        t_burn();
        summarize();
    end
endmodule // adcp_postprocess_bench

`default_nettype wire
